// ### rtl/swr_cfg.svh
// Constants for the sleep, wake and reset controller
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH
`define SWR_ADDR_W 8
`define SWR_OFS_CONFIG 8'h00
`define SWR_OFS_PWRSTAT 8'h04
`define SWR_OFS_EVSTAT 8'h08
`define SWR_OFS_EVCLR 8'h0c
`define SWR_OFS_EVEN 8'h10
`define SWR_OFS_WDTCNT 8'h14
`define SWR_CONFIG_RST 32'h0000_0000
`define SWR_PWR_RST 32'h0000_000c
`define SWR_EV_RST 5'h00
`define SWR_IRQ_N 8
`define SWR_STACK_TOP 5'h10
`define SWR_STACK_BOT 5'h00
`define SWR_OST_PERIODS 11'h400
`define SWR_ISR_VECTOR 15'h0004
`define SWR_WDT_CNT_W 24
`define SWR_WDT_TICKS_MS 24'h00_0020
`define SWR_WDT_SEL_MAX 5'h12
`endif

// ### rtl/swr_pkg.sv
// Types for the sleep, wake and reset controller
package swr_pkg;
   typedef enum logic [1:0] {SWR_WDM_OFF, SWR_WDM_SW, SWR_WDM_NOSLP, SWR_WDM_ON} swr_wdm_t;
   typedef enum logic [1:0] {SWR_OSC_XTAL, SWR_OSC_EXT, SWR_OSC_RC, SWR_OSC_INT} swr_osc_t;
   typedef enum logic [1:0] {SWR_ST_RUN, SWR_ST_SLEEP, SWR_ST_OST, SWR_ST_WAKE} swr_state_t;
   typedef struct packed {
      logic [19:0] rsvd;
      logic two_speed;
      swr_osc_t osc_mode;
      logic [4:0] period_sel;
      logic wdt_sw_en;
      swr_wdm_t wdt_mode;
      logic stack_fault_reset_enable;
   } swr_config_t;
   typedef struct packed {
      logic [26:0] rsvd;
      logic watchdog_reset;
      logic powerdown_status_flag;
      logic timeout_status_flag;
      logic stack_underflow_flag;
      logic stack_overflow_flag;
   } swr_pwr_t;
   typedef struct packed {
      logic wake;
      logic wdt_wake;
      logic wdt_reset;
      logic stk_unf;
      logic stk_ovf;
   } swr_ev_t;
   typedef struct packed {
      logic halt_exec;
      logic watchdog_clear_instruction;
      logic stack_push;
      logic stack_pop;
   } swr_core_ev_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } swr_apb_req_t;
endpackage

// ### rtl/swr_wdt_core.sv
// Watchdog counter fed by its own clock pin
`timescale 1ns/100ps
`include "swr_cfg.svh"
module swr_wdt_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic wdt_clk_pin,
   input wire logic clear,
   input wire logic run,
   input wire logic [4:0] sel,
   output logic expire,
   output logic [`SWR_WDT_CNT_W-1:0] count
);
   logic sync1_ff;
   logic sync2_ff;
   logic sync3_ff;
   logic [`SWR_WDT_CNT_W-1:0] cnt_ff;
   logic [`SWR_WDT_CNT_W-1:0] limit;
   logic [4:0] sel_c;
   logic tick;

   // ---------------------------------------------
   // Pin synchroniser and rising edge detect
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= wdt_clk_pin;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end
   assign tick = sync2_ff & ~sync3_ff;

   // ---------------------------------------------
   // Period select and counter
   // ---------------------------------------------
   assign sel_c = (sel > `SWR_WDT_SEL_MAX) ? `SWR_WDT_SEL_MAX : sel;
   assign limit = (`SWR_WDT_TICKS_MS << sel_c) - 24'h00_0001;
   // A shorter period picked mid-count still expires on the next tick
   assign expire = run & tick & (cnt_ff >= limit);
   assign count = cnt_ff;

   always_ff @(posedge clk) begin
      if (rst || clear || expire) begin
         cnt_ff <= '0;
      end else if (run && tick) begin
         cnt_ff <= cnt_ff + 24'h00_0001;
      end
   end
endmodule

// ### rtl/swr_top.sv
// Sleep, wake, watchdog and stack fault reset controller
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "swr_cfg.svh"
// Function
// [RL1] Stack push past sixteen or pop past one resets when enabled, flags set
// [RL2] Any enabled and flagged interrupt wakes, regardless of global enable
// [RL3] Interrupt already pending at halt makes halt a no-op
// [RL4] No-op halt leaves watchdog, timeout and powerdown flags untouched
// [RL5] Interrupt during or after halt completes halt then wakes at once
// [RL6] Real sleep clears watchdog, sets timeout flag, clears powerdown flag
// [RL7] Wake vectors to 0004h with global enable, else resumes in line
// [RL8] Crystal mode wake waits 1024 oscillator periods; others skip it (the logic also skips it in crystal mode when two_speed is set)
// [RL9] Watchdog resets the device if not cleared within its period
// [RL10] Watchdog modes: always on, off in sleep, software, always off
// [RL11] Period 1 ms to 256 s, counted on independent watchdog clock
// [RL12] Watchdog expiry during sleep wakes the device and flags timeout
module swr_top
   import swr_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire swr_apb_req_t APB_REQ,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   input wire swr_core_ev_t CORE_EV,
   input wire logic [`SWR_IRQ_N-1:0] IRQ_FLAG,
   input wire logic [`SWR_IRQ_N-1:0] IRQ_ENABLE,
   input wire logic GLOBAL_INTERRUPT_ENABLE,
   input wire logic WDT_CLK_PIN,
   output logic IRQ,
   output logic SLEEPING,
   output logic CORE_RESET,
   output logic HALT_NOP,
   output logic RESUME,
   output logic RESUME_TO_ISR,
   output logic [14:0] ISR_ADDR
);
   swr_config_t cfg_ff;
   swr_pwr_t pwr_ff;
   swr_pwr_t nxt_pwr;
   swr_ev_t ev_stat_ff;
   swr_ev_t ev_en_ff;
   swr_ev_t ev_set;
   swr_state_t state_ff;
   swr_state_t nxt_state;
   logic [31:0] prdata_ff;
   logic slverr_ff;
   logic [31:0] rd_data;
   logic rd_err;
   logic wr_acc;
   logic setup;
   logic [4:0] depth_ff;
   logic [10:0] ost_ff;
   logic [10:0] ost_len_ff;
   logic core_reset_ff;
   logic halt_nop_ff;
   logic resume_ff;
   logic to_isr_ff;
   logic [14:0] isr_addr_ff;
   logic irq_wake;
   logic halt_sleep;
   logic halt_nop;
   logic ovf;
   logic unf;
   logic stk_fault;
   logic wdt_run;
   logic wdt_clear;
   logic wdt_expire;
   logic wdt_in_sleep;
   logic [`SWR_WDT_CNT_W-1:0] wdt_count;
   logic need_ost;
   logic sleeping;

   // ---------------------------------------------
   // APB slave
   // ---------------------------------------------
   assign setup = APB_REQ.psel & ~APB_REQ.penable;
   assign wr_acc = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
   assign PREADY = 1'b1;
   assign PRDATA = prdata_ff;
   assign PSLVERR = slverr_ff;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      unique case (APB_REQ.paddr)
         `SWR_OFS_CONFIG: rd_data = cfg_ff;
         `SWR_OFS_PWRSTAT: rd_data = pwr_ff;
         `SWR_OFS_EVSTAT: rd_data = {27'h000_0000, ev_stat_ff};
         `SWR_OFS_EVCLR: rd_data = 32'h0000_0000;
         `SWR_OFS_EVEN: rd_data = {27'h000_0000, ev_en_ff};
         `SWR_OFS_WDTCNT: rd_data = {8'h00, wdt_count};
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         prdata_ff <= 32'h0000_0000;
         slverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= APB_REQ.pwrite ? 32'h0000_0000 : rd_data;
         slverr_ff <= rd_err;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cfg_ff <= `SWR_CONFIG_RST;
      end else if (wr_acc && APB_REQ.paddr == `SWR_OFS_CONFIG) begin
         cfg_ff <= APB_REQ.pwdata;
      end
   end

   // ---------------------------------------------
   // Sleep and wake sequencing
   // ---------------------------------------------
   // [RL2] Enabled and flagged source wakes
   assign irq_wake = |(IRQ_FLAG & IRQ_ENABLE);
   // [RL3] Pending interrupt turns halt into no-op
   assign halt_nop = (state_ff == SWR_ST_RUN) & CORE_EV.halt_exec & irq_wake;
   // [RL4] Only real sleep touches flags
   assign halt_sleep = (state_ff == SWR_ST_RUN) & CORE_EV.halt_exec & ~irq_wake;
   // [RL8] Start-up delay only in crystal mode
   assign need_ost = (cfg_ff.osc_mode == SWR_OSC_XTAL) & ~cfg_ff.two_speed;
   assign sleeping = (state_ff == SWR_ST_SLEEP);
   assign wdt_in_sleep = sleeping & wdt_expire;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SWR_ST_RUN: begin
            if (halt_sleep) begin
               nxt_state = SWR_ST_SLEEP;
            end
         end
         SWR_ST_SLEEP: begin
            // [RL5] Wake right after halt completes
            if (irq_wake || wdt_in_sleep) begin
               nxt_state = need_ost ? SWR_ST_OST : SWR_ST_WAKE;
            end
         end
         SWR_ST_OST: begin
            if (ost_ff == `SWR_OST_PERIODS - 11'h001) begin
               nxt_state = SWR_ST_WAKE;
            end
         end
         SWR_ST_WAKE: nxt_state = SWR_ST_RUN;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RESET || core_reset_ff) begin
         state_ff <= SWR_ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // [RL8] Count oscillator periods before wake
   always_ff @(posedge CLOCK) begin
      if (RESET || state_ff != SWR_ST_OST) begin
         ost_ff <= 11'h000;
      end else begin
         ost_ff <= ost_ff + 11'h001;
      end
   end

   // [RL7] Vector to ISR or resume in line
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         resume_ff <= 1'b0;
         to_isr_ff <= 1'b0;
         isr_addr_ff <= `SWR_ISR_VECTOR;
         halt_nop_ff <= 1'b0;
      end else begin
         resume_ff <= (state_ff == SWR_ST_WAKE);
         to_isr_ff <= (state_ff == SWR_ST_WAKE) & GLOBAL_INTERRUPT_ENABLE;
         isr_addr_ff <= `SWR_ISR_VECTOR;
         halt_nop_ff <= halt_nop;
      end
   end
   assign RESUME = resume_ff;
   assign RESUME_TO_ISR = to_isr_ff;
   assign ISR_ADDR = isr_addr_ff;
   assign HALT_NOP = halt_nop_ff;
   assign SLEEPING = (state_ff != SWR_ST_RUN);

   // ---------------------------------------------
   // Stack depth tracking
   // ---------------------------------------------
   // [RL1] Push beyond top or pop below bottom
   assign ovf = CORE_EV.stack_push & ~CORE_EV.stack_pop & (depth_ff == `SWR_STACK_TOP);
   assign unf = CORE_EV.stack_pop & ~CORE_EV.stack_push & (depth_ff == `SWR_STACK_BOT);
   assign stk_fault = cfg_ff.stack_fault_reset_enable & (ovf | unf);

   always_ff @(posedge CLOCK) begin
      if (RESET || core_reset_ff) begin
         depth_ff <= `SWR_STACK_BOT;
      end else if (CORE_EV.stack_push && !CORE_EV.stack_pop && !ovf) begin
         depth_ff <= depth_ff + 5'h01;
      end else if (CORE_EV.stack_pop && !CORE_EV.stack_push && !unf) begin
         depth_ff <= depth_ff - 5'h01;
      end
   end

   // ---------------------------------------------
   // Watchdog
   // ---------------------------------------------
   // [RL10] Four operating modes
   always_comb begin
      unique case (cfg_ff.wdt_mode)
         SWR_WDM_OFF: wdt_run = 1'b0;
         SWR_WDM_SW: wdt_run = cfg_ff.wdt_sw_en;
         SWR_WDM_NOSLP: wdt_run = ~SLEEPING;
         SWR_WDM_ON: wdt_run = 1'b1;
      endcase
   end
   // [RL6] Real sleep entry clears the watchdog
   assign wdt_clear = CORE_EV.watchdog_clear_instruction | halt_sleep | core_reset_ff;

   // [RL11] Independent clock, selectable period
   swr_wdt_core u_wdt (
      .clk(CLOCK),
      .rst(RESET),
      .wdt_clk_pin(WDT_CLK_PIN),
      .clear(wdt_clear),
      .run(wdt_run),
      .sel(cfg_ff.period_sel),
      .expire(wdt_expire),
      .count(wdt_count)
   );

   // [RL9] Expiry while running resets; [RL1] stack fault resets
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         core_reset_ff <= 1'b0;
      end else begin
         core_reset_ff <= (wdt_expire & ~sleeping) | stk_fault;
      end
   end
   assign CORE_RESET = core_reset_ff;

   // ---------------------------------------------
   // Power control status flags
   // ---------------------------------------------
   always_comb begin
      nxt_pwr = pwr_ff;
      if (wr_acc && APB_REQ.paddr == `SWR_OFS_PWRSTAT) begin
         nxt_pwr.stack_overflow_flag = pwr_ff.stack_overflow_flag & ~APB_REQ.pwdata[0];
         nxt_pwr.stack_underflow_flag = pwr_ff.stack_underflow_flag & ~APB_REQ.pwdata[1];
         nxt_pwr.watchdog_reset = pwr_ff.watchdog_reset & ~APB_REQ.pwdata[4];
      end
      // [RL1] Flag the stack fault
      if (ovf) begin
         nxt_pwr.stack_overflow_flag = 1'b1;
      end
      if (unf) begin
         nxt_pwr.stack_underflow_flag = 1'b1;
      end
      // [RL6] Sleep sets timeout, clears powerdown
      if (halt_sleep) begin
         nxt_pwr.timeout_status_flag = 1'b1;
         nxt_pwr.powerdown_status_flag = 1'b0;
      end
      // [RL12] Expiry clears timeout, sleep wake or reset
      if (wdt_expire) begin
         nxt_pwr.timeout_status_flag = 1'b0;
         nxt_pwr.watchdog_reset = ~sleeping;
      end
      nxt_pwr.rsvd = '0;
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         pwr_ff <= `SWR_PWR_RST;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   // ---------------------------------------------
   // Event status, clear and enable
   // ---------------------------------------------
   assign ev_set = '{wake: (state_ff == SWR_ST_WAKE), wdt_wake: wdt_in_sleep,
      wdt_reset: wdt_expire & ~sleeping, stk_unf: unf, stk_ovf: ovf};

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ev_stat_ff <= `SWR_EV_RST;
      end else if (wr_acc && APB_REQ.paddr == `SWR_OFS_EVCLR) begin
         ev_stat_ff <= (ev_stat_ff & ~APB_REQ.pwdata[4:0]) | ev_set;
      end else begin
         ev_stat_ff <= ev_stat_ff | ev_set;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ev_en_ff <= `SWR_EV_RST;
      end else if (wr_acc && APB_REQ.paddr == `SWR_OFS_EVEN) begin
         ev_en_ff <= APB_REQ.pwdata[4:0];
      end
   end
   assign IRQ = |(ev_stat_ff & ev_en_ff);

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   a_nop_no_sleep: assert property (halt_nop |=> state_ff == SWR_ST_RUN && HALT_NOP) // [RL3]
      else $error("no-op halt entered sleep");
   a_nop_flags_kept: assert property (halt_nop && !wdt_expire |=> // [RL4]
      pwr_ff.timeout_status_flag == $past(pwr_ff.timeout_status_flag)
      && pwr_ff.powerdown_status_flag == $past(pwr_ff.powerdown_status_flag))
      else $error("no-op halt changed flags");
   a_sleep_flags: assert property (halt_sleep && !wdt_expire |=> // [RL6]
      pwr_ff.timeout_status_flag && !pwr_ff.powerdown_status_flag && wdt_count == '0)
      else $error("sleep entry flags wrong");
   a_wake_fast: assert property (sleeping && irq_wake && !need_ost && !core_reset_ff // [RL5]
      |=> state_ff == SWR_ST_WAKE ##1 RESUME)
      else $error("wake not immediate");
   a_wake_vector: assert property (state_ff == SWR_ST_WAKE // [RL7]
      |=> RESUME_TO_ISR == $past(GLOBAL_INTERRUPT_ENABLE) && ISR_ADDR == `SWR_ISR_VECTOR)
      else $error("wake vector wrong");
   // [RL8] Helper count of start-up cycles
   always_ff @(posedge CLOCK) begin
      if (RESET || state_ff != SWR_ST_OST) begin
         ost_len_ff <= 11'h000;
      end else begin
         ost_len_ff <= ost_len_ff + 11'h001;
      end
   end

   a_ost_length: assert property (state_ff == SWR_ST_OST && !core_reset_ff // [RL8]
      |=> (state_ff == SWR_ST_OST) == (ost_len_ff < `SWR_OST_PERIODS))
      else $error("start-up delay length wrong");
   a_stack_reset: assert property (stk_fault |=> CORE_RESET // [RL1]
      && (pwr_ff.stack_overflow_flag || pwr_ff.stack_underflow_flag))
      else $error("stack fault not reset");
   a_wdt_reset: assert property (wdt_expire && !sleeping |=> CORE_RESET // [RL9]
      && !pwr_ff.timeout_status_flag)
      else $error("watchdog expiry did not reset");
   a_wdt_off: assert property (cfg_ff.wdt_mode == SWR_WDM_OFF |-> !wdt_expire) // [RL10]
      else $error("watchdog ran while off");
   a_wdt_sleep_wake: assert property (wdt_in_sleep |=> !CORE_RESET // [RL12]
      && state_ff != SWR_ST_SLEEP && ev_stat_ff.wdt_wake)
      else $error("sleep expiry did not wake");
   a_gie_ignored: assert property (sleeping && irq_wake && !GLOBAL_INTERRUPT_ENABLE // [RL2]
      && !core_reset_ff |=> state_ff != SWR_ST_SLEEP)
      else $error("wake needed global enable");

   c_sleep_wake: cover property (halt_sleep ##[1:20] RESUME);
   c_halt_nop: cover property (halt_nop);
   c_wdt_rst: cover property (wdt_expire && !sleeping);
   c_stack_ovf: cover property (ovf && stk_fault);
endmodule

// ### verif/swr_core_model.sv
// Model of the core instruction flow and interrupt sources
`timescale 1ns/100ps
module swr_core_model
   import swr_pkg::*;
(
   input wire logic clk,
   input wire logic resume,
   input wire logic resume_to_isr,
   input wire logic [14:0] isr_addr,
   output swr_core_ev_t core_ev,
   output logic [7:0] irq_flag,
   output logic [7:0] irq_enable,
   output logic global_interrupt_enable,
   output logic watchdog_clk,
   output logic [14:0] pc
);
   // ----------------------------------------
   // Core side
   // ----------------------------------------
   // Halt sits at 0100h until a wake picks the next fetch
   initial begin
      core_ev = '0;
      irq_flag = 8'h00;
      irq_enable = 8'h00;
      global_interrupt_enable = 1'b0;
      watchdog_clk = 1'b0;
      pc = 15'h0100;
   end

   // Watchdog clock runs free, unrelated in phase to the system clock
   always #41.5 watchdog_clk = ~watchdog_clk;

   always @(posedge clk) begin
      if (resume === 1'b1) begin
         pc <= resume_to_isr ? isr_addr : pc + 15'h0001;
      end
   end

   // One-cycle instruction event
   task pulse(input swr_core_ev_t ev);
      @(posedge clk);
      core_ev <= ev;
      @(posedge clk);
      core_ev <= '0;
   endtask

   task irq(input logic [7:0] f, input logic [7:0] e, input logic g);
      @(posedge clk);
      irq_flag <= f;
      irq_enable <= e;
      global_interrupt_enable <= g;
   endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the sleep, wake and reset controller
`timescale 1ns/100ps
`include "swr_cfg.svh"
module testbench
   import swr_pkg::*;
;
   localparam logic [7:0] a_cfg = `SWR_OFS_CONFIG;
   localparam logic [7:0] a_ps = `SWR_OFS_PWRSTAT;
   localparam logic [7:0] a_ev = `SWR_OFS_EVSTAT;
   localparam logic [7:0] a_clr = `SWR_OFS_EVCLR;
   localparam logic [7:0] a_en = `SWR_OFS_EVEN;
   localparam logic [7:0] a_cnt = `SWR_OFS_WDTCNT;
   logic clock, reset, pready, pslverr, irq, sleeping, core_reset, halt_nop;
   logic resume, resume_to_isr, global_interrupt_enable, watchdog_clk, err;
   logic [31:0] prdata, rd;
   logic [14:0] isr_addr, pc;
   logic [7:0] irq_flag, irq_enable;
   swr_apb_req_t apb_req;
   swr_core_ev_t core_ev;
   int n_mismatch, checks;

   initial clock = 1'b0;
   always #4 clock = ~clock;

   swr_top dut (
      .CLOCK(clock),
      .RESET(reset),
      .APB_REQ(apb_req),
      .PREADY(pready),
      .PRDATA(prdata),
      .PSLVERR(pslverr),
      .CORE_EV(core_ev),
      .IRQ_FLAG(irq_flag),
      .IRQ_ENABLE(irq_enable),
      .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable),
      .WDT_CLK_PIN(watchdog_clk),
      .IRQ(irq),
      .SLEEPING(sleeping),
      .CORE_RESET(core_reset),
      .HALT_NOP(halt_nop),
      .RESUME(resume),
      .RESUME_TO_ISR(resume_to_isr),
      .ISR_ADDR(isr_addr)
   );

   swr_core_model core (
      .clk(clock),
      .resume(resume),
      .resume_to_isr(resume_to_isr),
      .isr_addr(isr_addr),
      .core_ev(core_ev),
      .irq_flag(irq_flag),
      .irq_enable(irq_enable),
      .global_interrupt_enable(global_interrupt_enable),
      .watchdog_clk(watchdog_clk),
      .pc(pc)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task give_verdict;
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask

   task ok(input logic c);
      chk({31'h0, c}, 32'h1);
   endtask

   task to_fail;
      n_mismatch++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      give_verdict();
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clock);
      apb_req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
      if (i == 16) to_fail();
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask

   // Waits for resume, core reset, sleep or no-op halt
   task wait_on(input int s, input int lim, input bit must, output int n);
      for (n = 0; n < lim; n++) begin
         #1;
         if ((s == 0 && resume === 1'b1) || (s == 1 && core_reset === 1'b1) ||
             (s == 2 && sleeping === 1'b1) || (s == 3 && halt_nop === 1'b1)) break;
         @(posedge clock);
      end
      if (must && n == lim) to_fail();
   endtask

   function logic [31:0] cfg(input logic sf, input swr_wdm_t m, input logic sw,
                             input logic [4:0] sel, input swr_osc_t o, input logic ts);
      swr_config_t c;
      c = '0;
      c.stack_fault_reset_enable = sf;
      c.wdt_mode = m;
      c.wdt_sw_en = sw;
      c.period_sel = sel;
      c.osc_mode = o;
      c.two_speed = ts;
      return c;
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      rdc(a_ps, 32'hffffffff, `SWR_PWR_RST);
      rdc(a_cfg, 32'hffffffff, `SWR_CONFIG_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      chk({17'h0, isr_addr}, 32'h4);
   endtask

   task t_wdt;
      int n, k;
      swr_wdm_t ms [4];
      ms = '{SWR_WDM_OFF, SWR_WDM_SW, SWR_WDM_SW, SWR_WDM_NOSLP};
      wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h00, SWR_OSC_EXT, 1'b0));
      wait_on(1, 800, 1'b1, n);
      ok(n > 250 && n < 500);
      rdc(a_ps, 32'h14, 32'h10);
      wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h01, SWR_OSC_EXT, 1'b0));
      wait_on(1, 1200, 1'b1, n);
      ok(n > 550 && n < 900);
      wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h00, SWR_OSC_EXT, 1'b0));
      for (k = 0; k < 6; k++) begin
         core.pulse(4'h4);
         wait_on(1, 150, 1'b0, n);
         chk(n, 150);
      end
      for (k = 0; k < 4; k++) begin
         wr(a_cfg, cfg(1'b0, ms[k], k == 2, 5'h00, SWR_OSC_EXT, 1'b0));
         wait_on(1, 500, 1'b0, n);
         ok((n < 500) == (k >= 2));
      end
      wr(a_cfg, 32'h0);
   endtask

   task t_nop;
      int n;
      logic [31:0] c0;
      wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h05, SWR_OSC_EXT, 1'b0));
      repeat (200) @(posedge clock);
      apb(1'b0, a_cnt, 32'h0);
      c0 = rd;
      core.irq(8'h01, 8'h01, 1'b0);
      core.pulse(4'h8);
      wait_on(3, 4, 1'b1, n);
      rdc(a_ps, 32'hc, 32'h8);
      ok(sleeping === 1'b0);
      apb(1'b0, a_cnt, 32'h0);
      ok(rd >= c0);
      core.irq(8'h00, 8'h00, 1'b0);
   endtask

   task t_sleep;
      int n, k;
      for (k = 0; k < 2; k++) begin
         wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h05, SWR_OSC_EXT, 1'b0));
         repeat (200) @(posedge clock);
         core.pulse(4'h8);
         wait_on(2, 4, 1'b1, n);
         rdc(a_ps, 32'hc, 32'h4);
         apb(1'b0, a_cnt, 32'h0);
         ok(rd < 32'h8);
         core.irq(8'h80, 8'h7f, k[0]);
         wait_on(0, 8, 1'b0, n);
         chk(n, 8);
         core.irq(8'h80, 8'h80, k[0]);
         wait_on(0, 8, 1'b1, n);
         chk({31'h0, resume_to_isr}, k);
         @(posedge clock);
         #1;
         chk({17'h0, pc}, k ? 32'h4 : 32'h101);
         core.irq(8'h00, 8'h00, 1'b0);
      end
   endtask

   task t_ost;
      int n, k;
      swr_osc_t om [5];
      om = '{SWR_OSC_XTAL, SWR_OSC_XTAL, SWR_OSC_EXT, SWR_OSC_RC, SWR_OSC_INT};
      for (k = 0; k < 5; k++) begin
         wr(a_cfg, cfg(1'b0, SWR_WDM_OFF, 1'b0, 5'h00, om[k], k == 1));
         core.pulse(4'h8);
         wait_on(2, 4, 1'b1, n);
         core.irq(8'h02, 8'h02, 1'b0);
         wait_on(0, 1100, 1'b1, n);
         ok(k == 0 ? n > 1020 && n < 1040 : n < 8);
         core.irq(8'h00, 8'h00, 1'b0);
      end
      wr(a_ps, 32'h13);
      wr(a_cfg, cfg(1'b0, SWR_WDM_NOSLP, 1'b0, 5'h00, SWR_OSC_EXT, 1'b0));
      core.pulse(4'h8);
      wait_on(2, 4, 1'b1, n);
      wait_on(0, 600, 1'b0, n);
      chk(n, 600);
      wr(a_cfg, cfg(1'b0, SWR_WDM_ON, 1'b0, 5'h00, SWR_OSC_EXT, 1'b0));
      wait_on(0, 600, 1'b1, n);
      rdc(a_ev, 32'h8, 32'h8);
      rdc(a_ps, 32'h14, 32'h0);
      wr(a_cfg, 32'h0);
   endtask

   task t_stack;
      int n;
      wr(a_cfg, cfg(1'b1, SWR_WDM_OFF, 1'b0, 5'h00, SWR_OSC_EXT, 1'b0));
      wr(a_ps, 32'h13);
      repeat (16) core.pulse(4'h2);
      wait_on(1, 4, 1'b0, n);
      chk(n, 4);
      rdc(a_ps, 32'h3, 32'h0);
      core.pulse(4'h2);
      wait_on(1, 4, 1'b1, n);
      rdc(a_ps, 32'h3, 32'h1);
      core.pulse(4'h1);
      wait_on(1, 4, 1'b1, n);
      rdc(a_ps, 32'h3, 32'h3);
      wr(a_en, 32'h0);
      #1;
      ok(irq === 1'b0);
      wr(a_en, 32'h1);
      #1;
      ok(irq === 1'b1);
      wr(a_clr, 32'h1);
      #1;
      ok(irq === 1'b0);
      rdc(a_ev, 32'h1, 32'h0);
      rdc(a_clr, 32'hffffffff, 32'h0);
   endtask

   initial begin
      n_mismatch = 0;
      checks = 0;
      reset = 1'b1;
      apb_req = '0;
      rd = 32'h0;
      err = 1'b0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_reset;
      t_wdt;
      t_nop;
      t_sleep;
      t_ost;
      t_stack;
      give_verdict();
   end
endmodule
